//--- shared/bfd_pkg.sv
// Constants for the branch field decoder: reset values, flag positions, call addresses, opcodes and branch target select codes.
// Assumes instruction bit n, counted from the most significant end, maps to vector index 31-n.
package bfd_pkg;
   localparam int unsigned BFD_WORD_W = 32;
   localparam logic [31:0] BFD_COND_RESET = 32'h0000_0000;
   localparam logic [31:0] BFD_LR_RESET = 32'h0000_0000;
   localparam logic [31:0] BFD_CTR_RESET = 32'h0000_0000;
   localparam logic [31:0] BFD_FXE_RESET = 32'h0000_0000;
   localparam logic [31:0] BFD_IA_RESET = 32'h0000_0000;
   localparam logic [31:0] BFD_CALL_FIXED_ADDR = 32'h0000_1FE0;
   localparam logic [31:0] BFD_WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] BFD_ALIGN_MASK = 32'hFFFF_FFFC;
   // Primary opcodes used to classify the branch-unit and fixed-point extended instructions.
   localparam logic [5:0] BFD_OP_BC = 6'h10;
   localparam logic [5:0] BFD_OP_SVC = 6'h11;
   localparam logic [5:0] BFD_OP_B = 6'h12;
   localparam logic [5:0] BFD_OP_XL = 6'h13;
   localparam logic [5:0] BFD_OP_FX_EXT = 6'h1F;
   localparam logic [9:0] BFD_XL_TO_LR = 10'h010;
   localparam logic [9:0] BFD_XL_TO_CTR = 10'h210;
   localparam logic [4:0] BFD_ZERO5 = 5'h00;
   // Positions in the fixed exception register of the excess flags.
   localparam int unsigned BFD_FXE_STICKY_POS = 31;
   localparam int unsigned BFD_FXE_EXCESS_POS = 30;
   typedef enum logic [1:0] {
      BFD_TGT_REL = 2'b00,
      BFD_TGT_ABS = 2'b01,
      BFD_TGT_CTR = 2'b11,
      BFD_TGT_LR = 2'b10
   } bfd_target_t;
endpackage : bfd_pkg

//--- logic/bfd_mask_gen.sv
// Rotate mask generator: builds a run of ones from a begin index to an end index, wrapping.
// Assumes indices use big-endian numbering, index 0 being the most significant bit.
`timescale 1ns/1ns
module bfd_mask_gen
   import bfd_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input wire logic [4:0] mask_begin_i,
   input wire logic [4:0] mask_end_i,
   output logic [WIDTH-1:0] mask_o
);
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         // Index i counts from the most significant end.
         if (mask_begin_i <= mask_end_i) begin
            mask_o[WIDTH-1-i] = (5'(i) >= mask_begin_i) && (5'(i) <= mask_end_i);
         end else begin
            mask_o[WIDTH-1-i] = (5'(i) >= mask_begin_i) || (5'(i) <= mask_end_i);
         end
      end
   end
endmodule : bfd_mask_gen

//--- logic/bfd_cond_eval.sv
// Branch condition evaluator: decides taken and counter decrement from the option field.
// Assumes the condition bit and decremented count are supplied by the caller.
`timescale 1ns/1ns
module bfd_cond_eval
   import bfd_pkg::*;
(
   input wire logic [4:0] branch_options_i,
   input wire logic cond_bit_i,
   input wire logic [31:0] ctr_next_i,
   output logic dec_ctr_o,
   output logic taken_o
);
   logic ctr_ok;
   logic cond_ok;
   always_comb begin
      // Option bit 2, counted from the most significant end, set means no counter is used.
      dec_ctr_o = ~branch_options_i[2];
      ctr_ok = branch_options_i[2] | ((ctr_next_i != 32'h0000_0000) ^ branch_options_i[1]);
      cond_ok = branch_options_i[4] | (cond_bit_i == branch_options_i[3]);
      taken_o = ctr_ok & cond_ok;
   end
endmodule : bfd_cond_eval

//--- logic/bfd_decoder.sv
// Branch field decoder top: splits words into fields, forms targets and owns the condition, link,
// count and fixed exception registers.
// Assumes the fetch stage presents one word with its address and a valid strobe; outputs are registered.
`timescale 1ns/1ns
module bfd_decoder
   import bfd_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic insn_valid_i,
   input wire logic [31:0] insn_word_i,
   input wire logic [31:0] insn_addr_i,
   input wire logic [31:0] fx_result_i,
   input wire logic fx_overflow_i,
   input wire logic fx_carry_i,
   input wire logic [3:0] fp_summary_i,
   output logic [5:0] primary_opcode_o,
   output logic [9:0] extended_opcode_o,
   output logic [4:0] gpr_a_select_o,
   output logic [4:0] gpr_b_select_o,
   output logic [4:0] gpr_dest_select_o,
   output logic [15:0] simm_o,
   output logic [15:0] halfword_unsigned_imm_o,
   output logic [4:0] rotate_count_o,
   output logic [4:0] string_byte_count_o,
   output logic [31:0] rotate_mask_o,
   output logic [9:0] special_reg_select_o,
   output logic [3:0] segment_reg_select_o,
   output logic [4:0] trap_condition_mask_o,
   output logic [3:0] fp_field_imm_o,
   output logic [31:0] branch_target_o,
   output logic branch_taken_o,
   output logic privilege_fault_o,
   output logic [31:0] condition_reg_o,
   output logic [31:0] link_reg_o,
   output logic [31:0] count_reg_o,
   output logic [31:0] fixed_exception_reg_o
);
   // Instruction bit n is vector index 31-n, so field (a:b) is [31-a:31-b].
   logic [31:0] w;
   assign w = insn_word_i;
   logic [5:0] op;
   logic link_enable_bit;
   logic absolute_addr_bit;
   logic call_absolute_bit;
   logic record_bit;
   logic overflow_enable;
   logic [4:0] branch_options;
   logic [4:0] cond_bit_select;
   logic [6:0] call_vector_index;
   logic [23:0] branch_offset_imm;
   logic [13:0] cond_offset_imm;
   logic [9:0] xl_opcode;
   assign op = w[31:26];
   assign link_enable_bit = w[0];
   assign record_bit = w[0];
   assign absolute_addr_bit = w[1];
   assign call_absolute_bit = w[1];
   assign overflow_enable = w[10];
   assign branch_options = w[25:21];
   assign cond_bit_select = w[20:16];
   assign call_vector_index = w[11:5];
   assign branch_offset_imm = w[25:2];
   assign cond_offset_imm = w[15:2];
   assign xl_opcode = w[10:1];

   logic [31:0] disp;
   logic [31:0] next_addr;
   logic [31:0] ctr_dec;
   logic is_b;
   logic is_bc;
   logic is_xl_br;
   logic is_svc;
   logic is_branch;
   logic dec_ctr;
   logic cond_taken;
   bfd_target_t tgt_sel;
   logic [31:0] target_raw;
   logic [31:0] mask;
   logic [31:0] cr_fields;

   assign next_addr = insn_addr_i + BFD_WORD_STEP;
   assign ctr_dec = count_reg_o - 32'h0000_0001;
   assign is_b = op == BFD_OP_B;
   assign is_bc = op == BFD_OP_BC;
   assign is_svc = op == BFD_OP_SVC;
   assign is_xl_br = (op == BFD_OP_XL) && ((xl_opcode == BFD_XL_TO_LR) || (xl_opcode == BFD_XL_TO_CTR));
   assign is_branch = is_b | is_bc | is_xl_br;

   bfd_cond_eval u_cond (
      .branch_options_i(branch_options),
      .cond_bit_i(condition_reg_o[31-cond_bit_select]),
      .ctr_next_i(ctr_dec),
      .dec_ctr_o(dec_ctr),
      .taken_o(cond_taken)
   );

   bfd_mask_gen #(.WIDTH(WIDTH)) u_mask (
      .mask_begin_i(w[10:6]),
      .mask_end_i(w[5:1]),
      .mask_o(mask)
   );

   always_comb begin
      if (is_b) begin
         disp = {{6{branch_offset_imm[23]}}, branch_offset_imm, 2'b00};
      end else begin
         disp = {{16{cond_offset_imm[13]}}, cond_offset_imm, 2'b00};
      end
      if (is_xl_br) begin
         tgt_sel = (xl_opcode == BFD_XL_TO_LR) ? BFD_TGT_LR : BFD_TGT_CTR;
      end else if (absolute_addr_bit) begin
         tgt_sel = BFD_TGT_ABS;
      end else begin
         tgt_sel = BFD_TGT_REL;
      end
      case (tgt_sel)
         BFD_TGT_REL: target_raw = disp + insn_addr_i;
         BFD_TGT_ABS: target_raw = disp;
         BFD_TGT_LR: target_raw = link_reg_o;
         BFD_TGT_CTR: target_raw = count_reg_o;
         default: target_raw = disp;
      endcase
      if (is_svc) begin
         if (call_absolute_bit) begin
            target_raw = BFD_CALL_FIXED_ADDR;
         end else begin
            target_raw = {20'h0_0000, 1'b1, call_vector_index, 4'h0} << 1;
         end
      end
      cr_fields = condition_reg_o;
      if (op == BFD_OP_FX_EXT) begin
         cr_fields[31:28] = {fx_result_i[31], ~fx_result_i[31] && (fx_result_i != 32'h0000_0000),
                             fx_result_i == 32'h0000_0000,
                             fixed_exception_reg_o[BFD_FXE_STICKY_POS] | (overflow_enable & fx_overflow_i)};
      end else begin
         cr_fields[27:24] = fp_summary_i;
      end
   end

   // Field extraction, registered per valid word.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         primary_opcode_o <= 6'h00;
         extended_opcode_o <= 10'h000;
         gpr_a_select_o <= 5'h00;
         gpr_b_select_o <= 5'h00;
         gpr_dest_select_o <= 5'h00;
         simm_o <= 16'h0000;
         halfword_unsigned_imm_o <= 16'h0000;
         rotate_count_o <= 5'h00;
         string_byte_count_o <= 5'h00;
         rotate_mask_o <= 32'h0000_0000;
         special_reg_select_o <= 10'h000;
         segment_reg_select_o <= 4'h0;
         trap_condition_mask_o <= 5'h00;
         fp_field_imm_o <= 4'h0;
      end else if (insn_valid_i) begin
         primary_opcode_o <= op;
         extended_opcode_o <= w[10:1];
         gpr_a_select_o <= w[20:16];
         gpr_b_select_o <= w[15:11];
         gpr_dest_select_o <= w[25:21];
         simm_o <= w[15:0];
         halfword_unsigned_imm_o <= w[15:0];
         rotate_count_o <= w[15:11];
         string_byte_count_o <= w[15:11];
         rotate_mask_o <= mask;
         special_reg_select_o <= w[20:11];
         segment_reg_select_o <= w[19:16];
         trap_condition_mask_o <= w[25:21];
         fp_field_imm_o <= w[15:12];
      end
   end

   // Branch result: target and taken flag; no privilege check exists for branches.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         branch_target_o <= BFD_IA_RESET;
         branch_taken_o <= 1'b0;
         privilege_fault_o <= 1'b0;
      end else begin
         privilege_fault_o <= 1'b0;
         branch_taken_o <= insn_valid_i && (is_b || is_svc || ((is_bc || is_xl_br) && cond_taken));
         if (insn_valid_i && (is_branch || is_svc)) begin
            branch_target_o <= target_raw & BFD_ALIGN_MASK;
         end
      end
   end

   // Link register: a register-indirect branch reads the old value before it is replaced.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         link_reg_o <= BFD_LR_RESET;
      end else if (insn_valid_i && link_enable_bit && (is_branch || is_svc)) begin
         link_reg_o <= next_addr;
      end
   end

   // Count register decrements only for BFD_OP_BC conditional forms that test it, not for register-indirect forms.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         count_reg_o <= BFD_CTR_RESET;
      end else if (insn_valid_i && is_bc && dec_ctr) begin
         count_reg_o <= ctr_dec;
      end
   end

   // Condition register changes only when the record bit is set.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         condition_reg_o <= BFD_COND_RESET;
      end else if (insn_valid_i && record_bit && !is_branch && !is_svc && (op != BFD_OP_XL)) begin
         condition_reg_o <= cr_fields;
      end
   end

   // The sticky flag only ever sets; the excess flag follows each enabled result.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fixed_exception_reg_o <= BFD_FXE_RESET;
      end else if (insn_valid_i && (op == BFD_OP_FX_EXT) && overflow_enable) begin
         fixed_exception_reg_o[BFD_FXE_EXCESS_POS] <= fx_overflow_i;
         fixed_exception_reg_o[BFD_FXE_STICKY_POS] <= fixed_exception_reg_o[BFD_FXE_STICKY_POS] | fx_overflow_i;
         fixed_exception_reg_o[29] <= fx_carry_i;
      end
   end
endmodule : bfd_decoder

//--- sim/bfd_decoder_assertions.sv
// Checker for the branch field decoder, seeing only the ports of its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module bfd_decoder_assertions
   import bfd_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic insn_valid_i,
   input wire logic [31:0] insn_word_i,
   input wire logic [31:0] insn_addr_i,
   input wire logic [5:0] primary_opcode_o,
   input wire logic [9:0] extended_opcode_o,
   input wire logic [4:0] gpr_a_select_o,
   input wire logic [4:0] gpr_b_select_o,
   input wire logic [4:0] gpr_dest_select_o,
   input wire logic [15:0] simm_o,
   input wire logic [15:0] halfword_unsigned_imm_o,
   input wire logic [4:0] rotate_count_o,
   input wire logic [4:0] string_byte_count_o,
   input wire logic [9:0] special_reg_select_o,
   input wire logic [3:0] segment_reg_select_o,
   input wire logic [4:0] trap_condition_mask_o,
   input wire logic [3:0] fp_field_imm_o,
   input wire logic [31:0] branch_target_o,
   input wire logic branch_taken_o,
   input wire logic privilege_fault_o,
   input wire logic [31:0] link_reg_o
);
   logic [31:0] w_q;
   logic [31:0] a_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Keeping the taken word lets each check compare against exact field slices.
   always_ff @(posedge clk_i) begin
      w_q <= insn_word_i;
      a_q <= insn_addr_i;
   end
   sequence s_issue(op);
      insn_valid_i && insn_word_i[31:26] == op;
   endsequence
   sequence s_called;
      branch_taken_o && branch_target_o == (w_q[1] ? BFD_CALL_FIXED_ADDR : {19'h0, 1'h1, w_q[11:5], 5'h0});
   endsequence
   fault_free_a: assert property (!privilege_fault_o)
      else $error("privilege fault raised");
   target_align_a: assert property (branch_taken_o |-> branch_target_o[1:0] == 2'h0)
      else $error("branch target not word aligned");
   field_split_a: assert property (insn_valid_i |=>
      primary_opcode_o == w_q[31:26] && extended_opcode_o == w_q[10:1]) else $error("opcode fields wrong");
   reg_select_a: assert property (insn_valid_i |=> gpr_a_select_o == w_q[20:16]
      && gpr_b_select_o == w_q[15:11] && gpr_dest_select_o == w_q[25:21]) else $error("register selects wrong");
   imm_split_a: assert property (insn_valid_i |=> simm_o == w_q[15:0] &&
      halfword_unsigned_imm_o == w_q[15:0] && rotate_count_o == w_q[15:11] && string_byte_count_o == w_q[15:11])
      else $error("immediate fields wrong");
   special_sel_a: assert property (insn_valid_i |=> special_reg_select_o == w_q[20:11]
      && segment_reg_select_o == w_q[19:16] && trap_condition_mask_o == w_q[25:21] && fp_field_imm_o == w_q[15:12])
      else $error("select fields wrong");
   svc_call_a: assert property (s_issue(BFD_OP_SVC) |=> s_called)
      else $error("call target wrong");
   rel_branch_a: assert property (s_issue(BFD_OP_B) |=> branch_taken_o &&
      branch_target_o == (((w_q[1] ? 32'h0 : a_q) + {{6{w_q[25]}}, w_q[25:2], 2'h0}) & BFD_ALIGN_MASK))
      else $error("branch target wrong");
   link_write_a: assert property (insn_valid_i && insn_word_i[0] &&
      (insn_word_i[31:26] == BFD_OP_B || insn_word_i[31:26] == BFD_OP_SVC) |=> link_reg_o == a_q + BFD_WORD_STEP)
      else $error("link register not loaded");
   link_hold_a: assert property (s_issue(BFD_OP_B) ##0 !insn_word_i[0] |=> $stable(link_reg_o))
      else $error("link register changed");
endmodule : bfd_decoder_assertions
bind bfd_decoder bfd_decoder_assertions i_chk (.*);

//--- sim/bfd_fetch_model.sv
// Fetch-stage model: presents one word and its address per bench request.
// Assumes the bench changes requests on the falling edge of clk_i.
`timescale 1ns/1ns
module bfd_fetch_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] word_i,
   input wire logic [31:0] addr_i,
   output logic insn_valid_o,
   output logic [31:0] insn_word_o,
   output logic [31:0] insn_addr_o
);
   logic [31:0] word_q = '0;
   logic [31:0] addr_q = '0;
   always @(posedge clk_i) if (req_i) {word_q, addr_q} <= {word_i, addr_i};
   // Between words the bus shows inverted data, so a stale word cannot pass for a fresh one.
   assign insn_valid_o = req_i;
   assign insn_word_o = req_i ? word_i : ~word_q;
   assign insn_addr_o = req_i ? addr_i : ~addr_q;
endmodule : bfd_fetch_model

//--- sim/branch_field_decoder_tb_top.sv
// Bench for the branch field decoder: directed branch, call and fixed-point words, then random words.
// Assumes a 100 ns clock; every design input changes on the falling edge.
`timescale 1ns/1ns
module branch_field_decoder_tb_top
   import bfd_pkg::*;
;
   typedef struct packed {
      logic [31:0] m, t;
      logic k;
      logic [31:0] l, c, r, x;
   } bfd_tb_exp_t;
   localparam logic [31:0] DIR [10] = '{{6'h12, 24'hFF_FFF0, 2'h1}, {6'h12, 24'h00_0400, 2'h2},
      {6'h11, 14'h0, 7'h55, 3'h0, 2'h1}, {6'h11, 14'h0, 7'h55, 3'h0, 2'h2}, 32'h7C00_0001, 32'h7C00_0400,
      32'h4080_0040, 32'h4200_FFC0, 32'h4E80_0020, 32'h4E80_0420};
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic req = 1'b0;
   logic [31:0] word = '0, addr = '0, fx_result_i = '0, w;
   logic fx_overflow_i = 1'b0, fx_carry_i = 1'b0, seen = 1'b0;
   logic [3:0] fp_summary_i = '0;
   logic [15:0] rnd = 16'h6A9C;
   logic [31:0] lr = '0, ctr = '0, cnd = '0, fxe = '0;
   wire logic insn_valid_i;
   wire logic [31:0] insn_word_i, insn_addr_i;
   logic [31:0] rotate_mask_o, branch_target_o, condition_reg_o, link_reg_o, count_reg_o, fixed_exception_reg_o;
   logic [15:0] simm_o, halfword_unsigned_imm_o;
   logic [9:0] extended_opcode_o, special_reg_select_o;
   logic [5:0] primary_opcode_o;
   logic [4:0] gpr_a_select_o, gpr_b_select_o, gpr_dest_select_o, rotate_count_o, string_byte_count_o;
   logic [4:0] trap_condition_mask_o;
   logic [3:0] segment_reg_select_o, fp_field_imm_o;
   logic branch_taken_o, privilege_fault_o;
   int fail_count = 0, check_count = 0;
   bfd_tb_exp_t exp_q[$];
   bfd_tb_exp_t e, g;
   bfd_decoder i_dut (.*);
   bfd_fetch_model i_fetch (.clk_i(clk_i), .req_i(req), .word_i(word), .addr_i(addr),
      .insn_valid_o(insn_valid_i), .insn_word_o(insn_word_i), .insn_addr_o(insn_addr_i));
   initial forever #50 clk_i = ~clk_i;
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : step
   function automatic logic [31:0] run_mask(input logic [4:0] b, input logic [4:0] n);
      logic [31:0] m;
      for (int i = 0; i < 32; i++) m[31-i] = (b <= n) ? (i >= b && i <= n) : (i >= b || i <= n);
      return m;
   endfunction : run_mask
   task automatic send(input logic [31:0] v, input logic [31:0] a);
      logic [5:0] op;
      logic [31:0] base;
      bfd_tb_exp_t x;
      @(negedge clk_i);
      rnd = step(rnd);
      {req, word, addr, fx_result_i, fx_overflow_i, fx_carry_i, fp_summary_i} = {1'h1, v, a, rnd, step(rnd), rnd[5:0]};
      op = v[31:26];
      base = v[1] ? 32'h0 : a;
      {x.k, x.t} = '0;
      case (op)
         BFD_OP_B: {x.k, x.t} = {1'h1, base + {{6{v[25]}}, v[25:2], 2'h0}};
         BFD_OP_SVC: {x.k, x.t} = {1'h1, v[1] ? BFD_CALL_FIXED_ADDR : {19'h0, 1'h1, v[11:5], 5'h0}};
         BFD_OP_BC: begin
            if (!v[23]) ctr = ctr - 1;
            x.k = (v[23] || ((ctr != 0) ^ v[22])) && (v[25] || cnd[31 - v[20:16]] == v[24]);
            x.t = base + {{16{v[15]}}, v[15:2], 2'h0};
         end
         BFD_OP_XL: {x.k, x.t} = {1'h1, v[10] ? ctr : lr};
         BFD_OP_FX_EXT: if (v[10]) fxe[31:29] = {fxe[31] | fx_overflow_i, fx_overflow_i, fx_carry_i};
         default: ;
      endcase
      x.t &= BFD_ALIGN_MASK;
      if (v[0] && op == BFD_OP_FX_EXT) cnd[31:28] = {fx_result_i[31], !fx_result_i[31] && fx_result_i != 0,
         fx_result_i == 0, fxe[31]};
      else if (v[0] && !(op inside {[BFD_OP_BC:BFD_OP_XL]})) cnd[27:24] = fp_summary_i;
      if (v[0] && (op == BFD_OP_B || op == BFD_OP_SVC)) lr = a + BFD_WORD_STEP;
      x.m = run_mask(v[10:6], v[5:1]);
      {x.l, x.c, x.r, x.x} = {lr, ctr, cnd, fxe};
      exp_q.push_back(x);
   endtask : send
   task automatic reset_dut();
      {req, sys_rst_i} = 2'h1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      {lr, ctr, cnd, fxe} = '0;
   endtask : reset_dut
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   always @(posedge clk_i) seen <= insn_valid_i && !sys_rst_i;
   always @(negedge clk_i) begin
      if (seen) begin
         e = exp_q.pop_front();
         g = {rotate_mask_o, e.k ? branch_target_o : e.t, branch_taken_o, link_reg_o, count_reg_o,
            condition_reg_o, fixed_exception_reg_o};
         check_count++;
         if (g !== e) begin
            fail_count++;
            $display("unexpected decode outputs: expected %h seen %h", e, g);
         end
      end
   end
   initial begin
      reset_dut();
      for (int i = 0; i < 10; i++) send(DIR[i], 32'h0000_4000 + 4 * i);
      @(negedge clk_i);
      reset_dut();
      // Random words avoid the branch opcodes, whose effects the directed table covers.
      for (int i = 0; i < 60; i++) begin
         rnd = step(rnd);
         w = {rnd[6] ? BFD_OP_FX_EXT : {1'h1, rnd[4:0]}, rnd[9:0], step(rnd)};
         if (w[10]) w[0] = 1'b0;
         send(w, {16'h0, rnd[13:0], 2'h0});
      end
      @(negedge clk_i);
      req = 1'b0;
      repeat (2) @(negedge clk_i);
      end_sim();
   end
   initial begin
      repeat (400) @(posedge clk_i);
      fail_count++;
      end_sim();
   end
endmodule : branch_field_decoder_tb_top
